// [logic/acf_pkg.sv]
// How it works
// - Chip select high releases serial output.
// - Output released 6 to 10 periods after the last clock edge.
// - Any channel positive, any other negative.
// - Probe bit enables source and sink currents.
// - Buffer on when pin AND bit.
// - Eight gains, powers of two, 1 to 128.
// - Offset trim is 8-bit sign-magnitude.
// - Offset trim shifts input up to half scale.
// - Ready goes low when calibration completes.
package acf_pkg;

	// Clock and timing, in nanoseconds, oscillator periods or clock cycles.
	localparam int CLK_PERIOD_NS = 100;
	localparam int OSC_PERIOD_NS = 100;
	localparam int TRI_MIN_OSC = 6;
	localparam int TRI_MAX_OSC = 10;
	localparam int RESET_GAP_OSC = 16;
	localparam int TRI_MIN_CYC =
		(TRI_MIN_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_GAP_CYC =
		(RESET_GAP_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Input synchroniser plus decode eat four to five cycles; only two are subtracted here.
	localparam int SYNC_LAT_CYC = 2;
	localparam logic [3:0] TRI_WAIT = 4'(TRI_MIN_CYC - SYNC_LAT_CYC);
	localparam logic [4:0] RESET_GAP = 5'(RESET_GAP_CYC);

	// Calibration lengths in data-ready periods.
	localparam logic [2:0] CAL_SINGLE_TICKS = 3'h2;
	localparam logic [2:0] CAL_FULL_TICKS = 3'h4;

	// Command bytes.
	localparam logic [7:0] OP_READ_RESULT = 8'h01;
	localparam logic [7:0] OP_READ_CONT = 8'h03;
	localparam logic [7:0] OP_STOP_CONT = 8'h0F;
	localparam logic [3:0] OP_READ_CONFIG = 4'h1;
	localparam logic [3:0] OP_WRITE_CONFIG = 4'h5;
	localparam logic [7:0] OP_SELF_FULL = 8'hF0;
	localparam logic [7:0] OP_SELF_OFFSET = 8'hF1;
	localparam logic [7:0] OP_SELF_GAIN = 8'hF2;
	localparam logic [7:0] OP_SYS_OFFSET = 8'hF3;
	localparam logic [7:0] OP_SYS_GAIN = 8'hF4;
	localparam logic [7:0] OP_SYNC_FILTER = 8'hFC;
	localparam logic [7:0] OP_SLEEP = 8'hFD;
	localparam logic [7:0] OP_RESET = 8'hFE;

	// Register indices.
	localparam logic [3:0] REG_MUX_SELECT = 4'h0;
	localparam logic [3:0] REG_ANALOG_SETUP = 4'h1;
	localparam logic [3:0] REG_OFFSET_TRIM = 4'h2;

	// Field positions.
	localparam int MUX_POS_LSB = 4;
	localparam int MUX_NEG_LSB = 0;
	localparam int ASW_GAIN_LSB = 0;
	localparam int ASW_BUFFER_BIT = 3;
	localparam int ASW_PROBE_BIT = 4;
	localparam int TRIM_SIGN_BIT = 7;

	// Reset values.
	localparam logic [7:0] MUX_SELECT_RST = 8'h01;
	localparam logic [7:0] ANALOG_SETUP_RST = 8'h00;
	localparam logic [7:0] OFFSET_TRIM_RST = 8'h00;

	// Frame lengths in bits.
	localparam logic [4:0] RESULT_BITS = 5'h18;
	localparam logic [4:0] CONFIG_BITS = 5'h08;

endpackage

// [logic/acf_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module acf_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Raw asynchronous inputs.
	input wire logic [W-1:0] pin,
	// Filtered level and one-cycle edge pulses.
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	// Three stages; a change counts only once stages two and three agree.
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					s1_q <= INIT[i];
					s2_q <= INIT[i];
					s3_q <= INIT[i];
					lvl_q <= INIT[i];
					rise_q <= 1'b0;
					fall_q <= 1'b0;
				end else begin
					s1_q <= pin[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
					fall_q <= (s2_q == s3_q) && !s3_q && lvl_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign level[i] = lvl_q;
			assign rise[i] = rise_q;
			assign fall[i] = fall_q;
		end
	endgenerate
endmodule
`default_nettype wire

// [logic/acf_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module acf_ctrl
	import acf_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Serial port from the host.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	// Conversion engine side.
	input wire logic data_tick,
	input wire logic [23:0] result_word,
	output logic result_ready_n,
	// Buffer strap pin.
	input wire logic buffer_pin_enable,
	// Analog front-end controls.
	output logic [2:0] mux_pos_sel,
	output logic [2:0] mux_neg_sel,
	output logic probe_source_en,
	output logic probe_sink_en,
	output logic buffer_on,
	output logic [2:0] gain_code,
	output logic [7:0] gain_onehot,
	output logic offset_shift_neg,
	output logic [6:0] offset_shift_mag,
	// Filter and power controls.
	output logic filter_sync,
	output logic sleep_mode,
	output logic calibrating
);
	typedef enum logic [1:0] {SP_CMD, SP_ARG, SP_OUT} acf_sp_e;
	logic [3:0] lvl, rse, fll;
	logic cs_n_s, sclk_r, sclk_f, din_s, bufpin_s;
	acf_sp_e state_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] rx_q, cmd_q, rx_next;
	logic [23:0] tx_q;
	logic [4:0] tx_len_q, sent_q;
	logic cont_q;
	logic [3:0] rel_q;
	logic dout_oe_n_q;
	logic [4:0] guard_q;
	logic [2:0] cal_left_q;
	logic rdy_n_q;
	logic [7:0] mux_q, asw_q, trim_q;
	logic accept, cmd_fire, wr_fire, fin_edge, soft_rst, is_cal, read_go;
	logic [7:0] rd_data;
	acf_sync #(.W(4), .INIT(4'h1)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pin({buffer_pin_enable, din, sclk, cs_n}),
		.level(lvl),
		.rise(rse),
		.fall(fll)
	);
	assign cs_n_s = lvl[0];
	assign sclk_r = rse[1];
	assign sclk_f = fll[1];
	assign din_s = lvl[2];
	assign bufpin_s = lvl[3];
	// Edges are ignored while a reset settles or a trim runs.
	assign accept = !cs_n_s && (guard_q == 5'h00) &&
		(cal_left_q == 3'h0);
	assign rx_next = {rx_q[6:0], din_s};
	assign cmd_fire = accept && (state_q == SP_CMD) && sclk_r &&
		(bit_cnt_q == 3'h7);
	assign wr_fire = accept && (state_q == SP_ARG) && sclk_r &&
		(bit_cnt_q == 3'h7);
	assign fin_edge = accept && (state_q == SP_OUT) && sclk_r &&
		(sent_q == tx_len_q - 5'h01);
	assign soft_rst = cmd_fire && (rx_next == OP_RESET);
	assign is_cal = (rx_next == OP_SELF_FULL) || (rx_next == OP_SELF_OFFSET) ||
		(rx_next == OP_SELF_GAIN) || (rx_next == OP_SYS_OFFSET) ||
		(rx_next == OP_SYS_GAIN);
	assign read_go = cmd_fire && ((rx_next == OP_READ_RESULT) ||
		(rx_next == OP_READ_CONT));
	// Register read mux; unmapped indices read as zero.
	always_comb begin
		case (rx_next[3:0])
			REG_MUX_SELECT: rd_data = mux_q;
			REG_ANALOG_SETUP: rd_data = asw_q;
			REG_OFFSET_TRIM: rd_data = trim_q;
			default: rd_data = 8'h00;
		endcase
	end
	// Command shifter and transfer sequencer. Chip select high resets
	// the interface but leaves continuous mode armed.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= SP_CMD;
			bit_cnt_q <= 3'h0;
			rx_q <= 8'h00;
			cmd_q <= 8'h00;
			tx_q <= 24'h000000;
			tx_len_q <= 5'h00;
			sent_q <= 5'h00;
			cont_q <= 1'b0;
		end else if (cs_n_s || soft_rst) begin
			state_q <= SP_CMD;
			bit_cnt_q <= 3'h0;
			sent_q <= 5'h00;
			if (soft_rst) begin
				cont_q <= 1'b0;
			end
		end else if (accept) begin
			case (state_q)
				SP_CMD: begin
					if (sclk_r) begin
						rx_q <= rx_next;
						bit_cnt_q <= bit_cnt_q + 3'h1;
					end
					if (cmd_fire) begin
						sent_q <= 5'h00;
						if (read_go) begin
							tx_q <= result_word;
							tx_len_q <= RESULT_BITS;
							state_q <= SP_OUT;
							cont_q <= (rx_next == OP_READ_CONT);
						end else if (rx_next[7:4] == OP_READ_CONFIG) begin
							tx_q <= {rd_data, 16'h0000};
							tx_len_q <= CONFIG_BITS;
							state_q <= SP_OUT;
						end else if (rx_next[7:4] == OP_WRITE_CONFIG) begin
							cmd_q <= rx_next;
							state_q <= SP_ARG;
						end else if (rx_next == OP_STOP_CONT) begin
							cont_q <= 1'b0;
						end
					end else if (cont_q && data_tick && bit_cnt_q == 3'h0) begin
						// Continuous mode: each new result goes straight out.
						tx_q <= result_word;
						tx_len_q <= RESULT_BITS;
						sent_q <= 5'h00;
						state_q <= SP_OUT;
					end
				end
				SP_ARG: begin
					if (sclk_r) begin
						rx_q <= rx_next;
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == 3'h7) begin
							state_q <= SP_CMD;
						end
					end
				end
				SP_OUT: begin
					// Host samples on rising edges; data moves on falling ones.
					if (sclk_f && sent_q != 5'h00) begin
						tx_q <= {tx_q[22:0], 1'b0};
					end
					if (sclk_r) begin
						sent_q <= sent_q + 5'h01;
						if (fin_edge) begin
							state_q <= SP_CMD;
						end
					end
				end
				default: state_q <= SP_CMD;
			endcase
		end
	end

	// Output driver and late release after the final edge.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dout_oe_n_q <= 1'b1;
			rel_q <= 4'h0;
			dout <= 1'b0;
		end else begin
			dout <= tx_q[23];
			if (cs_n_s) begin
				dout_oe_n_q <= 1'b1;
				rel_q <= 4'h0;
			end else if (fin_edge) begin
				rel_q <= TRI_WAIT;
			end else if (state_q == SP_OUT) begin
				dout_oe_n_q <= 1'b0;
			end else if (rel_q == 4'h1) begin
				dout_oe_n_q <= 1'b1;
				rel_q <= 4'h0;
			end else if (rel_q != 4'h0) begin
				rel_q <= rel_q - 4'h1;
			end
		end
	end
	assign dout_oe_n = dout_oe_n_q;
	// Settle window after pin or command reset; the host must honour it.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			guard_q <= RESET_GAP;
		end else if (soft_rst) begin
			guard_q <= RESET_GAP;
		end else if (guard_q != 5'h00) begin
			guard_q <= guard_q - 5'h01;
		end
	end
	// Trim sequencing counted in data-ready periods.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cal_left_q <= 3'h0;
		end else if (cmd_fire && is_cal) begin
			if (rx_next == OP_SELF_FULL) begin
				cal_left_q <= CAL_FULL_TICKS;
			end else begin
				cal_left_q <= CAL_SINGLE_TICKS;
			end
		end else if (data_tick && cal_left_q != 3'h0) begin
			cal_left_q <= cal_left_q - 3'h1;
		end
	end

	// Ready flag: a new result or a finished trim beats a clearing read.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdy_n_q <= 1'b1;
		end else if (data_tick && cal_left_q <= 3'h1) begin
			rdy_n_q <= 1'b0;
		end else if (read_go || (cmd_fire && is_cal)) begin
			rdy_n_q <= 1'b1;
		end
	end
	assign result_ready_n = rdy_n_q;
	// Configuration registers.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mux_q <= MUX_SELECT_RST;
			asw_q <= ANALOG_SETUP_RST;
			trim_q <= OFFSET_TRIM_RST;
		end else if (soft_rst) begin
			mux_q <= MUX_SELECT_RST;
			asw_q <= ANALOG_SETUP_RST;
			trim_q <= OFFSET_TRIM_RST;
		end else if (wr_fire) begin
			case (cmd_q[3:0])
				REG_MUX_SELECT: begin
					// A pair must name two distinct, existing channels.
					if (rx_next[MUX_POS_LSB+:3] != rx_next[MUX_NEG_LSB+:3] &&
						32'(rx_next[MUX_POS_LSB+:3]) < NUM_CH &&
						32'(rx_next[MUX_NEG_LSB+:3]) < NUM_CH) begin
						mux_q <= rx_next;
					end
				end
				REG_ANALOG_SETUP: asw_q <= rx_next;
				REG_OFFSET_TRIM: trim_q <= rx_next;
				default: ;
			endcase
		end
	end

	// Front-end control outputs, all registered.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mux_pos_sel <= 3'h0;
			mux_neg_sel <= 3'h1;
			probe_source_en <= 1'b0;
			probe_sink_en <= 1'b0;
			buffer_on <= 1'b0;
			gain_code <= 3'h0;
			gain_onehot <= 8'h01;
			offset_shift_neg <= 1'b0;
			offset_shift_mag <= 7'h00;
		end else begin
			mux_pos_sel <= mux_q[MUX_POS_LSB+:3];
			mux_neg_sel <= mux_q[MUX_NEG_LSB+:3];
			probe_source_en <= asw_q[ASW_PROBE_BIT];
			probe_sink_en <= asw_q[ASW_PROBE_BIT];
			buffer_on <= asw_q[ASW_BUFFER_BIT] & bufpin_s;
			gain_code <= asw_q[ASW_GAIN_LSB+:3];
			gain_onehot <= 8'h01 << asw_q[ASW_GAIN_LSB+:3];
			// Full magnitude shifts by half the input range.
			offset_shift_neg <= trim_q[TRIM_SIGN_BIT];
			offset_shift_mag <= trim_q[6:0];
		end
	end

	// Filter sync pulse, sleep level and trim-busy level.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			filter_sync <= 1'b0;
			sleep_mode <= 1'b0;
			calibrating <= 1'b0;
		end else begin
			filter_sync <= cmd_fire && (rx_next == OP_SYNC_FILTER);
			calibrating <= (cmd_fire && is_cal) ||
				(cal_left_q > 3'h1) || (cal_left_q == 3'h1 && !data_tick);
			if (cmd_fire) begin
				sleep_mode <= (rx_next == OP_SLEEP);
			end
		end
	end
endmodule
`default_nettype wire

// [verification/acf_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module acf_ctrl_asserts #(
	parameter int NUM_CH = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Watched ports.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout_oe_n,
	input wire logic data_tick,
	input wire logic result_ready_n,
	input wire logic calibrating,
	input wire logic buffer_pin_enable,
	input wire logic buffer_on,
	input wire logic [2:0] mux_pos_sel,
	input wire logic [2:0] mux_neg_sel,
	input wire logic probe_source_en,
	input wire logic probe_sink_en,
	input wire logic [2:0] gain_code,
	input wire logic [7:0] gain_onehot
);
	logic sclk_q;
	logic [3:0] quiet_q;
	logic [2:0] ticks_q;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// Cycles since the raw serial clock last rose, held at 15.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= 1'b0;
			quiet_q <= 4'h0;
		end else begin
			sclk_q <= sclk;
			if (sclk && !sclk_q) begin
				quiet_q <= 4'h0;
			end else if (quiet_q != 4'hF) begin
				quiet_q <= quiet_q + 4'h1;
			end
		end
	end
	// Data periods seen in one trim, so its length can be judged at the end.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ticks_q <= 3'h0;
		end else if (!calibrating) begin
			ticks_q <= 3'h0;
		end else if (data_tick) begin
			ticks_q <= ticks_q + 3'h1;
		end
	end
	a_probe_pair: assert property (
		probe_source_en == probe_sink_en) else $error("probe currents differ");
	a_buffer_and: assert property (
		!buffer_pin_enable [*6] |-> !buffer_on) else $error("buffer without pin");
	a_gain_onehot: assert property (
		gain_onehot == (8'h01 << gain_code)) else $error("gain mask wrong");
	a_mux_distinct: assert property (
		mux_pos_sel != mux_neg_sel) else $error("mux inputs equal");
	a_mux_range: assert property (
		mux_pos_sel < NUM_CH && mux_neg_sel < NUM_CH) else $error("mux range");
	a_cs_release: assert property (
		cs_n [*6] |-> dout_oe_n) else $error("driving while deselected");
	a_tri_window: assert property (
		$rose(dout_oe_n) && !cs_n |-> quiet_q >= 4'h6 && quiet_q <= 4'h9)
		else $error("release outside window");
	a_cal_start: assert property (
		$rose(calibrating) |-> result_ready_n) else $error("ready at trim start");
	a_cal_done: assert property (
		$fell(calibrating) |-> !result_ready_n &&
		(ticks_q == 3'h2 || ticks_q == 3'h4)) else $error("trim end wrong");
endmodule
bind acf_ctrl acf_ctrl_asserts #(.NUM_CH(NUM_CH)) u_asserts (
	.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
	.dout_oe_n(dout_oe_n), .data_tick(data_tick),
	.result_ready_n(result_ready_n), .calibrating(calibrating),
	.buffer_pin_enable(buffer_pin_enable), .buffer_on(buffer_on),
	.mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel),
	.probe_source_en(probe_source_en), .probe_sink_en(probe_sink_en),
	.gain_code(gain_code), .gain_onehot(gain_onehot)
);
`default_nettype wire

// [verification/acf_host.sv]
`timescale 1ns/1ps
`default_nettype none
module acf_host (
	// Clock.
	input wire logic mclk,
	// Serial port toward the device.
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	// The serial clock rests low between frames.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Waits whole periods, always ending on a falling edge.
	task automatic osc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Selects or deselects the device.
	task automatic sel(input logic on);
		cs_n = ~on;
	endtask
	// One byte MSB first; low phase six periods, high phase four. The
	// device needs about six periods after a falling edge to show a bit.
	task automatic xfer8(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			din = tx[i];
			osc(6);
			rx[i] = dout;
			sclk = 1'b1;
			osc(4);
			sclk = 1'b0;
		end
		din = ~din; // A released line must not keep its last bit.
	endtask
endmodule
`default_nettype wire

// [verification/adc_command_timing_frontend_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_command_timing_frontend_ctrl_bench
	import acf_pkg::*;
;
	logic mclk, reset_n, data_tick, buffer_pin_enable, cs_n, sclk, din, dout;
	logic dout_oe_n, result_ready_n, probe_source_en, probe_sink_en, buffer_on;
	logic offset_shift_neg, filter_sync, sleep_mode, calibrating;
	logic [23:0] result_word;
	logic [2:0] mux_pos_sel, mux_neg_sel, gain_code;
	logic [7:0] gain_onehot;
	logic [6:0] offset_shift_mag;
	logic dout_line;
	int bad_count = 0;
	int checks = 0;
	int syncs = 0;
	localparam logic [7:0] TRIMS [5] = '{OP_SELF_GAIN, OP_SELF_OFFSET,
		OP_SYS_OFFSET, OP_SYS_GAIN, OP_SELF_FULL};
	acf_ctrl #(.NUM_CH(8)) DUT (
		.mclk(mclk),
		.reset_n(reset_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.dout(dout),
		.dout_oe_n(dout_oe_n),
		.data_tick(data_tick),
		.result_word(result_word),
		.result_ready_n(result_ready_n),
		.buffer_pin_enable(buffer_pin_enable),
		.mux_pos_sel(mux_pos_sel),
		.mux_neg_sel(mux_neg_sel),
		.probe_source_en(probe_source_en),
		.probe_sink_en(probe_sink_en),
		.buffer_on(buffer_on),
		.gain_code(gain_code),
		.gain_onehot(gain_onehot),
		.offset_shift_neg(offset_shift_neg),
		.offset_shift_mag(offset_shift_mag),
		.filter_sync(filter_sync),
		.sleep_mode(sleep_mode),
		.calibrating(calibrating)
	);
	// A released data line shows the inverse of its last bit, so a read
	// taken while the device is not driving cannot pass by chance.
	assign dout_line = dout_oe_n ? ~dout : dout;
	acf_host host (
		.mclk(mclk),
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.dout(dout_line)
	);
	// Sync pulses are counted mid-cycle, where the one-cycle pulse stands.
	always @(negedge mclk) begin
		if (filter_sync === 1'b1) begin
			syncs++;
		end
	end
	// Free-running 10 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	function automatic logic [7:0] gain_mask(input logic [2:0] g);
		return 8'h01 << g;
	endfunction
	function automatic int trim_len(input logic [7:0] op);
		return (op == OP_SELF_FULL) ? 4 : 2;
	endfunction
	task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] r, input logic [7:0] v);
		logic [7:0] x;
		host.sel(1'b1);
		host.xfer8({OP_WRITE_CONFIG, r}, x);
		host.xfer8(v, x);
		host.sel(1'b0);
		host.osc(4);
	endtask
	task automatic rd(input logic [3:0] r, output logic [7:0] v);
		logic [7:0] x;
		host.sel(1'b1);
		host.xfer8({OP_READ_CONFIG, r}, x);
		host.osc(50);
		host.xfer8(8'h00, v);
		host.osc(12);
		chk("read release", 1'b1, dout_oe_n);
		host.sel(1'b0);
		host.osc(4);
	endtask
	task automatic tick();
		data_tick = 1'b1;
		host.osc(1);
		data_tick = 1'b0;
		host.osc(5);
	endtask
	// Hang guard, a little over twice the expected run.
	initial begin
		#2000000;
		bad_count++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		logic [7:0] v, asw;
		logic [2:0] p, n;
		logic [23:0] w;
		reset_n = 1'b0;
		data_tick = 1'b0;
		buffer_pin_enable = 1'b0;
		result_word = 24'h000000;
		void'($urandom(32'h57BC));
		repeat (20) @(negedge mclk);
		reset_n = 1'b1;
		host.osc(20);
		chk("reset state", 14'h0101, {mux_pos_sel, mux_neg_sel, gain_onehot});
		for (int g = 0; g < 8; g++) begin
			asw = {3'h0, 2'($urandom), 3'(g)};
			buffer_pin_enable = 1'($urandom);
			wr(REG_ANALOG_SETUP, asw);
			chk("gain", gain_mask(3'(g)), gain_onehot);
			chk("probe", {2{asw[ASW_PROBE_BIT]}}, {probe_source_en,
				probe_sink_en});
			chk("buffer", asw[ASW_BUFFER_BIT] & buffer_pin_enable, buffer_on);
			rd(REG_ANALOG_SETUP, v);
			chk("setup readback", asw, v);
		end
		repeat (6) begin
			p = 3'($urandom);
			n = p + 3'($urandom_range(7, 1));
			wr(REG_MUX_SELECT, {1'b0, p, 1'b0, n});
			wr(REG_MUX_SELECT, {1'b0, n, 1'b0, n});
			chk("mux", {p, n}, {mux_pos_sel, mux_neg_sel});
		end
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : 8'($urandom);
			wr(REG_OFFSET_TRIM, v);
			chk("trim", v, {offset_shift_neg, offset_shift_mag});
		end
		rd(4'hA, v);
		chk("unmapped", 8'h00, v);
		w = 24'($urandom);
		result_word = w;
		tick();
		chk("ready", 1'b0, result_ready_n);
		host.sel(1'b1);
		host.xfer8(OP_READ_RESULT, v);
		host.osc(50);
		for (int b = 2; b >= 0; b--) begin
			host.xfer8(8'h00, v);
			chk("result", w[8*b +: 8], v);
		end
		host.osc(12);
		chk("result release", 1'b1, dout_oe_n);
		host.sel(1'b0);
		host.osc(4);
		host.sel(1'b1);
		host.xfer8(OP_READ_RESULT, v);
		host.osc(50);
		host.xfer8(8'h00, v);
		chk("driving", 1'b0, dout_oe_n);
		host.sel(1'b0);
		host.osc(5);
		chk("abort release", 1'b1, dout_oe_n);
		// Continuous mode: the command sends the current result, then each
		// new result goes out by itself until the stop command.
		host.sel(1'b1);
		host.xfer8(OP_READ_CONT, v);
		host.osc(50);
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				w = 24'($urandom);
				result_word = w;
				tick();
			end
			for (int b = 2; b >= 0; b--) begin
				host.xfer8(8'h00, v);
				chk("stream", w[8*b +: 8], v);
			end
			host.osc(12);
		end
		host.xfer8(OP_STOP_CONT, v);
		tick();
		chk("stopped", 1'b1, dout_oe_n);
		host.xfer8(OP_SLEEP, v);
		host.osc(4);
		chk("sleep", 1'b1, sleep_mode);
		host.xfer8(OP_SYNC_FILTER, v);
		host.sel(1'b0);
		host.osc(4);
		chk("wake", 1'b0, sleep_mode);
		chk("sync pulses", 24'h000001, 24'(syncs));
		foreach (TRIMS[i]) begin
			host.sel(1'b1);
			host.xfer8(TRIMS[i], v);
			host.sel(1'b0);
			host.osc(8);
			chk("calibrating", 1'b1, calibrating);
			if (i == 0) wr(REG_ANALOG_SETUP, 8'h00);
			repeat (trim_len(TRIMS[i]) - 1) tick();
			chk("early ready", 1'b1, result_ready_n);
			tick();
			chk("trim done", 2'b00, {result_ready_n, calibrating});
		end
		chk("busy write", 3'h7, gain_code);
		host.sel(1'b1);
		host.xfer8(OP_RESET, v);
		host.sel(1'b0);
		host.osc(20);
		chk("reset cmd", 14'h0101, {mux_pos_sel, mux_neg_sel, gain_onehot});
		// A pin reset in mid-run must restore the front end as well.
		wr(REG_ANALOG_SETUP, 8'h17);
		chk("probe set", 1'b1, probe_source_en);
		reset_n = 1'b0;
		host.osc(3);
		reset_n = 1'b1;
		host.osc(20);
		chk("pin reset", 9'h001, {probe_source_en, gain_onehot});
		tally_and_finish();
	end
endmodule
`default_nettype wire
